// file: hdl/iea_pkg.sv
// Constants and carrier types for the I/O engine interrupt aggregator
package iea_pkg;

	localparam int unsigned SRC_WIDTH  = 12;
	localparam int unsigned LINE_COUNT = 2;
	localparam int unsigned ADDR_WIDTH = 12;
	localparam int unsigned DATA_WIDTH = 32;

	// Register byte addresses
	localparam logic [11:0] OFF_RAW_SOURCES   = 12'h0128;
	localparam logic [11:0] OFF_LINE0_ENABLE  = 12'h012C;
	localparam logic [11:0] OFF_LINE0_FORCE   = 12'h0130;
	localparam logic [11:0] OFF_LINE0_STATUS  = 12'h0134;
	localparam logic [11:0] OFF_LINE1_ENABLE  = 12'h0138;
	localparam logic [11:0] OFF_LINE1_FORCE   = 12'h013C;
	localparam logic [11:0] OFF_LINE1_STATUS  = 12'h0140;
	localparam logic [11:0] OFF_EVENT_STATUS  = 12'h0144;
	localparam logic [11:0] OFF_EVENT_MASK    = 12'h0148;

	// Reset values
	localparam logic [11:0] ENABLE_RESET      = 12'h0000;
	localparam logic [11:0] FORCE_RESET       = 12'h0000;
	localparam logic [11:0] RAW_RESET         = 12'h0000;
	localparam logic [2:0]  EVENT_RESET       = 3'h0;
	localparam logic [31:0] READ_IDLE         = 32'h0000_0000;

	// Field positions of the source word
	localparam int unsigned RX_LSB            = 0;
	localparam int unsigned TX_LSB            = 4;
	localparam int unsigned FLAG_LSB          = 8;

	// Event status bits
	localparam int unsigned EVENT_WIDTH       = 3;
	localparam int unsigned EV_LINE0_RISE     = 0;
	localparam int unsigned EV_LINE1_RISE     = 1;
	localparam int unsigned EV_BAD_ADDRESS    = 2;

	// Avalon-MM response codes
	localparam logic [1:0]  RESP_OKAY         = 2'h0;
	localparam logic [1:0]  RESP_SLAVEERROR   = 2'h2;

	// Raw interrupt sources, packed to match the source register layout
	typedef struct packed {
		logic [3:0] machineFlag;
		logic [3:0] txHasSpace;
		logic [3:0] rxHasData;
	} iea_raw_src_s;

	typedef enum logic [0:0] {
		BUS_IDLE   = 1'b0,
		BUS_ANSWER = 1'b1
	} iea_bus_state_e;

endpackage : iea_pkg

// file: hdl/iea_irq_aggregator.sv
// Interrupt aggregator: raw sources, per-line enable and force, status, Avalon-MM slave
//
// Decided for this implementation: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module iea_irq_aggregator (
	input  wire logic                   clk,
	input  wire logic                   sys_rst,
	input  wire logic [11:0]            address,
	input  wire logic                   read,
	input  wire logic                   write,
	input  wire logic [3:0]             byteenable,
	input  wire logic [31:0]            writedata,
	output logic      [31:0]            readdata,
	output logic      [1:0]             response,
	output logic                        waitrequest,
	input  wire iea_pkg::iea_raw_src_s  rawSources,
	output logic                        interruptLineZero,
	output logic                        interruptLineOne,
	output logic                        eventIrq
);

	localparam logic [11:0] LINE_STRIDE = iea_pkg::OFF_LINE1_ENABLE - iea_pkg::OFF_LINE0_ENABLE;

	iea_pkg::iea_bus_state_e         busState_reg;
	iea_pkg::iea_bus_state_e         busState_next;
	iea_pkg::iea_raw_src_s           raw_reg;
	logic [iea_pkg::SRC_WIDTH-1:0]   rawWord;
	logic [iea_pkg::SRC_WIDTH-1:0]   enable_reg [iea_pkg::LINE_COUNT];
	logic [iea_pkg::SRC_WIDTH-1:0]   force_reg  [iea_pkg::LINE_COUNT];
	logic [iea_pkg::SRC_WIDTH-1:0]   statusNow  [iea_pkg::LINE_COUNT];
	logic [iea_pkg::LINE_COUNT-1:0]  line_reg;
	logic [iea_pkg::LINE_COUNT-1:0]  line_next;
	logic [iea_pkg::EVENT_WIDTH-1:0] eventStatus_reg;
	logic [iea_pkg::EVENT_WIDTH-1:0] eventMask_reg;
	logic [iea_pkg::EVENT_WIDTH-1:0] eventSet;
	logic [iea_pkg::SRC_WIDTH-1:0]   writeMask;
	logic [iea_pkg::SRC_WIDTH-1:0]   writeBits;
	logic [31:0]                     readdata_next;
	logic                            request;
	logic                            commit;
	logic                            addrMapped;
	logic                            badAccess;

	// Bus handshake: every access waits one cycle, then completes
	assign request     = read | write;
	assign waitrequest = request & (busState_reg != iea_pkg::BUS_ANSWER);
	assign commit      = request & (busState_reg == iea_pkg::BUS_ANSWER);

	always_comb begin
		case (busState_reg)
			iea_pkg::BUS_IDLE: begin
				busState_next = request ? iea_pkg::BUS_ANSWER : iea_pkg::BUS_IDLE;
			end
			iea_pkg::BUS_ANSWER: begin
				busState_next = iea_pkg::BUS_IDLE;
			end
			default: begin
				busState_next = iea_pkg::BUS_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			busState_reg <= iea_pkg::BUS_IDLE;
		end else begin
			busState_reg <= busState_next;
		end
	end

	// Byte lanes 0 and 1 carry the twelve implemented bits
	assign writeMask = {{4{byteenable[1]}}, {8{byteenable[0]}}};
	assign writeBits = writedata[iea_pkg::SRC_WIDTH-1:0];

	always_comb begin
		case (address)
			iea_pkg::OFF_RAW_SOURCES,
			iea_pkg::OFF_LINE0_ENABLE,
			iea_pkg::OFF_LINE0_FORCE,
			iea_pkg::OFF_LINE0_STATUS,
			iea_pkg::OFF_LINE1_ENABLE,
			iea_pkg::OFF_LINE1_FORCE,
			iea_pkg::OFF_LINE1_STATUS,
			iea_pkg::OFF_EVENT_STATUS,
			iea_pkg::OFF_EVENT_MASK: begin
				addrMapped = 1'b1;
			end
			default: begin
				addrMapped = 1'b0;
			end
		endcase
	end

	assign badAccess = commit & ~addrMapped;

	// Raw sources sampled once per cycle
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			raw_reg <= iea_pkg::iea_raw_src_s'(iea_pkg::RAW_RESET);
		end else begin
			raw_reg <= rawSources;
		end
	end

	// Word layout: rx in 3:0, tx in 7:4, flags in 11:8
	assign rawWord = {raw_reg.machineFlag, raw_reg.txHasSpace, raw_reg.rxHasData};

	// One enable, force and status set per interrupt line
	for (genvar g = 0; g < iea_pkg::LINE_COUNT; g++) begin : gen_line
		localparam logic [11:0] OFF_EN = iea_pkg::OFF_LINE0_ENABLE + 12'(g) * LINE_STRIDE;
		localparam logic [11:0] OFF_FO = iea_pkg::OFF_LINE0_FORCE + 12'(g) * LINE_STRIDE;

		always_ff @(posedge clk) begin
			if (sys_rst) begin
				enable_reg[g] <= iea_pkg::ENABLE_RESET;
			end else if (commit && write && address == OFF_EN) begin
				enable_reg[g] <= (enable_reg[g] & ~writeMask) | (writeBits & writeMask);
			end
		end

		always_ff @(posedge clk) begin
			if (sys_rst) begin
				force_reg[g] <= iea_pkg::FORCE_RESET;
			end else if (commit && write && address == OFF_FO) begin
				force_reg[g] <= (force_reg[g] & ~writeMask) | (writeBits & writeMask);
			end
		end

		// Force wins regardless of source or enable
		assign statusNow[g] = (rawWord & enable_reg[g]) | force_reg[g];
		assign line_next[g] = |statusNow[g];
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			line_reg <= '0;
		end else begin
			line_reg <= line_next;
		end
	end

	assign interruptLineZero = line_reg[0];
	assign interruptLineOne  = line_reg[1];

	// Sticky events: line rising edges and accesses to unmapped addresses
	always_comb begin
		eventSet                          = '0;
		eventSet[iea_pkg::EV_LINE0_RISE]  = line_next[0] & ~line_reg[0];
		eventSet[iea_pkg::EV_LINE1_RISE]  = line_next[1] & ~line_reg[1];
		eventSet[iea_pkg::EV_BAD_ADDRESS] = badAccess;
	end

	// Write one to clear; a new event in the same cycle stays set
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			eventStatus_reg <= iea_pkg::EVENT_RESET;
		end else if (commit && write && address == iea_pkg::OFF_EVENT_STATUS && byteenable[0]) begin
			eventStatus_reg <= (eventStatus_reg & ~writedata[iea_pkg::EVENT_WIDTH-1:0]) | eventSet;
		end else begin
			eventStatus_reg <= eventStatus_reg | eventSet;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			eventMask_reg <= iea_pkg::EVENT_RESET;
		end else if (commit && write && address == iea_pkg::OFF_EVENT_MASK && byteenable[0]) begin
			eventMask_reg <= writedata[iea_pkg::EVENT_WIDTH-1:0];
		end
	end

	assign eventIrq = |(eventStatus_reg & eventMask_reg);

	// Read mux; reserved bits read as zero
	always_comb begin
		readdata_next = iea_pkg::READ_IDLE;
		case (address)
			iea_pkg::OFF_RAW_SOURCES: begin
				readdata_next[iea_pkg::SRC_WIDTH-1:0] = rawWord;
			end
			iea_pkg::OFF_LINE0_ENABLE: begin
				readdata_next[iea_pkg::SRC_WIDTH-1:0] = enable_reg[0];
			end
			iea_pkg::OFF_LINE0_FORCE: begin
				readdata_next[iea_pkg::SRC_WIDTH-1:0] = force_reg[0];
			end
			iea_pkg::OFF_LINE0_STATUS: begin
				readdata_next[iea_pkg::SRC_WIDTH-1:0] = statusNow[0];
			end
			iea_pkg::OFF_LINE1_ENABLE: begin
				readdata_next[iea_pkg::SRC_WIDTH-1:0] = enable_reg[1];
			end
			iea_pkg::OFF_LINE1_FORCE: begin
				readdata_next[iea_pkg::SRC_WIDTH-1:0] = force_reg[1];
			end
			iea_pkg::OFF_LINE1_STATUS: begin
				readdata_next[iea_pkg::SRC_WIDTH-1:0] = statusNow[1];
			end
			iea_pkg::OFF_EVENT_STATUS: begin
				readdata_next[iea_pkg::EVENT_WIDTH-1:0] = eventStatus_reg;
			end
			iea_pkg::OFF_EVENT_MASK: begin
				readdata_next[iea_pkg::EVENT_WIDTH-1:0] = eventMask_reg;
			end
			default: begin
				readdata_next = iea_pkg::READ_IDLE;
			end
		endcase
	end

	// Answer is captured in the waiting cycle and stands through the completing one
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			readdata <= iea_pkg::READ_IDLE;
		end else if (request && busState_reg == iea_pkg::BUS_IDLE) begin
			readdata <= read ? readdata_next : iea_pkg::READ_IDLE;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			response <= iea_pkg::RESP_OKAY;
		end else if (request && busState_reg == iea_pkg::BUS_IDLE) begin
			response <= addrMapped ? iea_pkg::RESP_OKAY : iea_pkg::RESP_SLAVEERROR;
		end
	end

endmodule : iea_irq_aggregator

`default_nettype wire

// file: testbench/iea_irq_aggregator_asserts.sv
// Port checker for the interrupt aggregator
`timescale 1ns/1ps
`default_nettype none
module iea_irq_aggregator_asserts (
	input wire logic                  clk,
	input wire logic                  sys_rst,
	input wire logic [11:0]           address,
	input wire logic                  read,
	input wire logic                  write,
	input wire logic [3:0]            byteenable,
	input wire logic [31:0]           writedata,
	input wire logic [31:0]           readdata,
	input wire logic                  waitrequest,
	input wire iea_pkg::iea_raw_src_s rawSources,
	input wire logic                  interruptLineZero,
	input wire logic                  interruptLineOne
);
	logic [11:0] rawReg, en0Reg, frc0Reg, en1Reg, frc1Reg, stat0, stat1;
	logic        rdDone;
	assign rdDone = read && !waitrequest;
	assign stat0 = rawReg & en0Reg | frc0Reg;
	assign stat1 = rawReg & en1Reg | frc1Reg;
	function automatic logic [11:0] lanes(input logic [11:0] old);
		return {byteenable[1] ? writedata[11:8] : old[11:8], byteenable[0] ? writedata[7:0] : old[7:0]};
	endfunction : lanes
	always_ff @(posedge clk) rawReg <= rawSources;
	// Shadow copies of the enable and force registers of both lines
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			{en0Reg, frc0Reg, en1Reg, frc1Reg} <= '0;
		end else if (write && !waitrequest) begin
			case (address)
				iea_pkg::OFF_LINE0_ENABLE: en0Reg <= lanes(en0Reg);
				iea_pkg::OFF_LINE0_FORCE: frc0Reg <= lanes(frc0Reg);
				iea_pkg::OFF_LINE1_ENABLE: en1Reg <= lanes(en1Reg);
				iea_pkg::OFF_LINE1_FORCE: frc1Reg <= lanes(frc1Reg);
				default: ;
			endcase
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	a_line0_level: assert property (interruptLineZero == |$past(stat0)) else $error("line zero level");
	a_line1_level: assert property (interruptLineOne == |$past(stat1)) else $error("line one level");
	a_en0_read: assert property (rdDone && address == iea_pkg::OFF_LINE0_ENABLE |->
		readdata[11:0] == $past(en0Reg)) else $error("enable zero readback");
	a_force0_read: assert property (rdDone && address == iea_pkg::OFF_LINE0_FORCE |->
		readdata[11:0] == $past(frc0Reg)) else $error("force zero readback");
	a_stat0_read: assert property (rdDone && address == iea_pkg::OFF_LINE0_STATUS |->
		readdata[11:0] == $past(stat0)) else $error("status zero readback");
	a_en1_read: assert property (rdDone && address == iea_pkg::OFF_LINE1_ENABLE |->
		readdata[11:0] == $past(en1Reg)) else $error("enable one readback");
	a_force1_read: assert property (rdDone && address == iea_pkg::OFF_LINE1_FORCE |->
		readdata[11:0] == $past(frc1Reg)) else $error("force one readback");
	a_stat1_read: assert property (rdDone && address == iea_pkg::OFF_LINE1_STATUS |->
		readdata[11:0] == $past(stat1)) else $error("status one readback");
	a_raw_read: assert property (rdDone && address == iea_pkg::OFF_RAW_SOURCES |->
		readdata == {20'h0_0000, $past(rawReg)}) else $error("raw readback");
endmodule : iea_irq_aggregator_asserts
bind iea_irq_aggregator iea_irq_aggregator_asserts chk (.clk, .sys_rst, .address, .read, .write, .byteenable,
	.writedata, .readdata, .waitrequest, .rawSources, .interruptLineZero, .interruptLineOne);
`default_nettype wire

// file: testbench/iea_cpu_intc.sv
// Processor interrupt controller model latching both lines as pending
`timescale 1ns/1ps
`default_nettype none
module iea_cpu_intc (
	input  wire logic       clk,
	input  wire logic       sys_rst,
	input  wire logic       lineZero,
	input  wire logic       lineOne,
	output logic      [1:0] pending
);
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pending <= 2'h0;
		end else begin
			pending <= pending | {lineOne, lineZero};
		end
	end
endmodule : iea_cpu_intc
`default_nettype wire

// file: testbench/iea_irq_aggregator_tb.sv
// Register-level tests of the interrupt aggregator
`timescale 1ns/1ps
`default_nettype none
module iea_irq_aggregator_tb;
	logic                  clk, sys_rst, read, write, waitrequest, interruptLineZero, interruptLineOne, eventIrq;
	logic [11:0]           address;
	logic [3:0]            byteenable;
	logic [31:0]           writedata, readdata, q;
	logic [1:0]            response, pending;
	iea_pkg::iea_raw_src_s rawSources;
	int                    errors, cmp_count;
	logic [11:0]           offs [9] = '{iea_pkg::OFF_RAW_SOURCES, iea_pkg::OFF_LINE0_ENABLE, iea_pkg::OFF_LINE0_FORCE,
		iea_pkg::OFF_LINE0_STATUS, iea_pkg::OFF_LINE1_ENABLE, iea_pkg::OFF_LINE1_FORCE, iea_pkg::OFF_LINE1_STATUS,
		iea_pkg::OFF_EVENT_STATUS, iea_pkg::OFF_EVENT_MASK};
	iea_irq_aggregator dut (.clk, .sys_rst, .address, .read, .write, .byteenable, .writedata, .readdata,
		.response, .waitrequest, .rawSources, .interruptLineZero, .interruptLineOne, .eventIrq);
	iea_cpu_intc intc (.clk, .sys_rst, .lineZero(interruptLineZero), .lineOne(interruptLineOne), .pending);
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		cmp_count++;
		if (seen !== want) begin
			errors++;
			$display("unexpected at %0t: got %h want %h", $time, seen, want);
		end
	endtask : check
	task automatic xfer(input logic w, input logic [11:0] a, input logic [3:0] be, input logic [31:0] d);
		@(posedge clk);
		address <= a;
		byteenable <= be;
		writedata <= d;
		read <= !w;
		write <= w;
		do @(negedge clk); while (waitrequest !== 1'b0);
		@(posedge clk);
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask : xfer
	task automatic rd(input logic [11:0] a, input logic [31:0] want);
		xfer(1'b0, a, 4'h3, 32'h0000_0000);
		check(q, want);
	endtask : rd
	task automatic pins(input logic [31:0] want);
		repeat (2) @(negedge clk);
		check({interruptLineOne, interruptLineZero, eventIrq}, want);
	endtask : pins
	task automatic results;
		$display("errors %0d comparisons %0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : results
	initial begin
		#20000;
		errors++;
		results();
	end
	initial begin
		{sys_rst, read, write, address, byteenable, writedata, rawSources} = {3'h4, 12'h000, 4'h0, 32'h0, 12'h000};
		repeat (10) @(posedge clk);
		sys_rst <= 1'b0;
		foreach (offs[i]) rd(offs[i], 32'h0000_0000);
		rawSources <= 12'hA53;
		rd(iea_pkg::OFF_RAW_SOURCES, 32'h0000_0A53);
		check(response, iea_pkg::RESP_OKAY);
		xfer(1'b1, iea_pkg::OFF_RAW_SOURCES, 4'h3, 32'h0000_0FFF);
		rd(iea_pkg::OFF_RAW_SOURCES, 32'h0000_0A53);
		xfer(1'b1, iea_pkg::OFF_LINE0_ENABLE, 4'h3, 32'hFFFF_F0F0);
		xfer(1'b1, iea_pkg::OFF_LINE1_ENABLE, 4'h1, 32'h0000_0FFF);
		rd(iea_pkg::OFF_LINE0_ENABLE, 32'h0000_00F0);
		rd(iea_pkg::OFF_LINE1_ENABLE, 32'h0000_00FF);
		rd(iea_pkg::OFF_LINE0_STATUS, 32'h0000_0050);
		rd(iea_pkg::OFF_LINE1_STATUS, 32'h0000_0053);
		pins(32'h0000_0006);
		check(pending, 32'h0000_0003);
		rd(iea_pkg::OFF_EVENT_STATUS, 32'h0000_0003);
		rawSources <= 12'h000;
		xfer(1'b1, iea_pkg::OFF_LINE1_FORCE, 4'h3, 32'h0000_0800);
		xfer(1'b1, iea_pkg::OFF_LINE0_FORCE, 4'h2, 32'h0000_0100);
		rd(iea_pkg::OFF_LINE1_STATUS, 32'h0000_0800);
		rd(iea_pkg::OFF_LINE0_STATUS, 32'h0000_0100);
		xfer(1'b1, iea_pkg::OFF_LINE0_FORCE, 4'h3, 32'h0000_0000);
		pins(32'h0000_0004);
		// Unmapped read raises the event interrupt, then mask and clear it
		xfer(1'b1, iea_pkg::OFF_EVENT_MASK, 4'h1, 32'h0000_0004);
		rd(12'h200, 32'h0000_0000);
		check(response, iea_pkg::RESP_SLAVEERROR);
		pins(32'h0000_0005);
		xfer(1'b1, iea_pkg::OFF_EVENT_MASK, 4'h1, 32'h0000_0000);
		pins(32'h0000_0004);
		xfer(1'b1, iea_pkg::OFF_EVENT_MASK, 4'h1, 32'h0000_0004);
		xfer(1'b1, iea_pkg::OFF_EVENT_STATUS, 4'h1, 32'h0000_0004);
		pins(32'h0000_0004);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		rd(iea_pkg::OFF_LINE1_FORCE, 32'h0000_0000);
		pins(32'h0000_0000);
		results();
	end
endmodule : iea_irq_aggregator_tb
`default_nettype wire
